// ==== rtl/phase_overcurrent_stage.v ====
// Operation
// - forcing enable gates manual status control
// - forced selector codes, default normal, gated
// - real currents still act while forcing
// - four independent stages with own settings
// - magnitude select RMS, TRMS or peak-to-peak
// - per-phase ratio of magnitude to threshold
// - common threshold, any phase exceeding picks up
// - release below 97 percent of threshold
// - threshold in 0.01 steps, default 1.20
// - bus writes need comm permission, default off
// - setting group switch while running
// - general settings independent of setting group
// - overall condition normal/start/trip/blocked
// - per-phase start and trip condition
// - expected operating time, 5 ms units
// - signed remaining time while timing
// - highest phase ratio in 0.01 units
// - unblocked pick-up asserts start, starts timing
// - blocked pick-up asserts blocked, stops processing
`timescale 1ns/100ps
`include "overcurrent_consts.vh"

module phase_overcurrent_stage #(
  parameter STAGES  = 4,
  parameter STAGE_W = 2,
  parameter GROUP_W = 3,
  parameter [20:0] TICK_CYCLES = `TICK_CYCLES
) (
  // clock, reset, enable
  input  wire                   clk_sys,
  input  wire                   rst,
  input  wire                   ce,
  // phase measurements, 0.01 x nominal current
  input  wire                   meas_valid,
  input  wire [15:0]            phase_one_fundamental,
  input  wire [15:0]            phase_two_fundamental,
  input  wire [15:0]            phase_three_fundamental,
  input  wire [15:0]            phase_one_true_rms,
  input  wire [15:0]            phase_two_true_rms,
  input  wire [15:0]            phase_three_true_rms,
  input  wire [15:0]            phase_one_peak_to_peak,
  input  wire [15:0]            phase_two_peak_to_peak,
  input  wire [15:0]            phase_three_peak_to_peak,
  // global control
  input  wire                   force_enable,
  input  wire [GROUP_W-1:0]     active_group,
  input  wire [STAGES-1:0]      block_in,
  // general settings write
  input  wire                   gen_wr,
  input  wire [STAGE_W-1:0]     gen_stage,
  input  wire                   gen_comm_allow,
  input  wire [4:0]             gen_force_sel,
  input  wire [1:0]             gen_mag_sel,
  // group settings write
  input  wire                   set_wr,
  input  wire                   set_from_bus,
  input  wire [STAGE_W-1:0]     set_stage,
  input  wire [GROUP_W-1:0]     set_group,
  input  wire [15:0]            set_threshold,
  input  wire [18:0]            set_delay,
  output reg                    set_refused,
  // stage outputs
  output wire [STAGES-1:0]      start_out,
  output wire [STAGES-1:0]      trip_out,
  output wire [STAGES-1:0]      blocked_out,
  output wire [2*STAGES-1:0]    condition,
  output wire [3*STAGES-1:0]    phase_start,
  output wire [3*STAGES-1:0]    phase_trip,
  output wire [5*STAGES-1:0]    forced_status_select,
  output wire [19*STAGES-1:0]   expected_time,
  output wire [20*STAGES-1:0]   time_remaining,
  output wire [16*STAGES-1:0]   ratio_max,
  output wire [48*STAGES-1:0]   phase_ratio
);

  localparam ENTRIES = STAGES << GROUP_W;
  localparam IW      = STAGE_W + GROUP_W;

  // forced code to {blocked, trip, start, trip mask, start mask}
  function [8:0] force_decode;
    input [4:0] code;
    reg   [4:0] k;
    reg   [2:0] m;
    begin
      k = 5'h00;
      m = 3'h0;
      force_decode = 9'h000;
      if (code >= `FORCE_TRIP_A && code <= `FORCE_TRIP_ABC)
        k = code - `FORCE_TRIP_A;
      else if (code >= `FORCE_START_A && code <= `FORCE_START_ABC)
        k = code - `FORCE_START_A;
      case (k)
        5'h00:   m = 3'h1;
        5'h01:   m = 3'h2;
        5'h02:   m = 3'h4;
        5'h03:   m = 3'h3;
        5'h04:   m = 3'h6;
        5'h05:   m = 3'h5;
        default: m = 3'h7;
      endcase
      case (code)
        `FORCE_NORMAL:  force_decode = 9'h000;
        `FORCE_START:   force_decode = 9'h040;
        `FORCE_TRIP:    force_decode = 9'h080;
        `FORCE_BLOCKED: force_decode = 9'h100;
        default:
        begin
          if (code >= `FORCE_TRIP_A && code <= `FORCE_TRIP_ABC)
            force_decode = {3'h0, m, 3'h0};
          else if (code >= `FORCE_START_A && code <= `FORCE_START_ABC)
            force_decode = {3'h0, 3'h0, m};
          else
            force_decode = 9'h000;
        end
      endcase
    end
  endfunction

  // general settings, one set per stage, not part of any group
  reg  [STAGES-1:0]   comm_allow_q;
  reg  [5*STAGES-1:0] force_sel_q;
  reg  [2*STAGES-1:0] mag_sel_q;
  // group settings
  reg  [15:0]         thr_mem [0:ENTRIES-1];
  reg  [18:0]         delay_mem [0:ENTRIES-1];
  // time base and processing cycle
  reg  [20:0]         tick_cnt_q;
  reg                 tick_q;
  reg                 eval_q;
  reg                 eval2_q;

  wire [IW-1:0] set_idx  = {set_stage, set_group};
  wire          set_ok   = !set_from_bus || comm_allow_q[set_stage];
  wire          range_ok = (set_threshold >= `THR_MIN) && (set_threshold <= `THR_MAX)
                           && (set_delay <= `DELAY_MAX);
  integer       i;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      comm_allow_q <= {STAGES{1'b0}};
      force_sel_q  <= {STAGES{`FORCE_NORMAL}};
      mag_sel_q    <= {STAGES{`MAG_RESET}};
      set_refused  <= 1'b0;
      for (i = 0; i < ENTRIES; i = i + 1)
      begin
        thr_mem[i]   <= `THR_RESET;
        delay_mem[i] <= `DELAY_RESET;
      end
    end
    else if (ce)
    begin
      set_refused <= set_wr && !(set_ok && range_ok);
      if (set_wr && set_ok && range_ok)
      begin
        thr_mem[set_idx]   <= set_threshold;
        delay_mem[set_idx] <= set_delay;
      end
      if (gen_wr)
      begin
        comm_allow_q[gen_stage]          <= gen_comm_allow;
        mag_sel_q[2*gen_stage +: 2]      <= gen_mag_sel;
        if (force_enable)
          force_sel_q[5*gen_stage +: 5]  <= gen_force_sel;
      end
      if (!force_enable)
        force_sel_q <= {STAGES{`FORCE_NORMAL}};
    end
  end

  // 5 ms tick and the processing cycle strobes
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      tick_cnt_q <= 21'h000000;
      tick_q     <= 1'b0;
      eval_q     <= 1'b0;
      eval2_q    <= 1'b0;
    end
    else if (ce)
    begin
      eval_q  <= meas_valid;
      eval2_q <= eval_q;
      tick_q  <= (tick_cnt_q == TICK_CYCLES - 21'h000001);
      if (tick_cnt_q == TICK_CYCLES - 21'h000001)
        tick_cnt_q <= 21'h000000;
      else
        tick_cnt_q <= tick_cnt_q + 21'h000001;
    end
  end

  wire [47:0] fund_v = {phase_three_fundamental, phase_two_fundamental, phase_one_fundamental};
  wire [47:0] trms_v = {phase_three_true_rms, phase_two_true_rms, phase_one_true_rms};
  wire [47:0] p2p_v  = {phase_three_peak_to_peak, phase_two_peak_to_peak,
                        phase_one_peak_to_peak};

  genvar g, p;
  generate
    for (g = 0; g < STAGES; g = g + 1)
    begin : stage
      localparam [STAGE_W-1:0] SI = g;

      reg  [47:0]   mag_q;
      reg  [2:0]    pick_q;
      reg  [1:0]    state_q;
      reg  [19:0]   rem_q;
      reg  [18:0]   exp_q;
      reg  [15:0]   rmax_q;
      reg           start_q;
      reg           trip_q;
      reg           blk_q;
      reg  [1:0]    cond_q;
      reg  [2:0]    ph_start_q;
      reg  [2:0]    ph_trip_q;
      reg  [4:0]    fsel_q;
      wire [1:0]    msel  = mag_sel_q[2*g +: 2];
      wire [15:0]   thr   = thr_mem[{SI, active_group}];
      wire [18:0]   delay = delay_mem[{SI, active_group}];
      wire [8:0]    fdec  = force_decode(force_enable ? force_sel_q[5*g +: 5]
                                                      : `FORCE_NORMAL);
      wire [2:0]    done_v;
      wire [47:0]   quot_v;
      wire          any_pick = |pick_q;
      wire [15:0]   q0 = quot_v[15:0];
      wire [15:0]   q1 = quot_v[31:16];
      wire [15:0]   q2 = quot_v[47:32];
      wire [15:0]   q01 = (q0 > q1) ? q0 : q1;

      for (p = 0; p < 3; p = p + 1)
      begin : phase
        wire [15:0] m     = mag_q[16*p +: 16];
        wire [22:0] m100  = m * `RATIO_SCALE;
        wire [22:0] thr97 = thr * `RESET_PCT;

        always @(posedge clk_sys)
        begin
          if (rst)
            pick_q[p] <= 1'b0;
          else if (ce && eval_q)
          begin
            if (m > thr)
              pick_q[p] <= 1'b1;
            else if (m100 < thr97)
              pick_q[p] <= 1'b0;
          end
        end

        ratio_divider u_div (
          .clk_sys (clk_sys),
          .rst     (rst),
          .ce      (ce),
          .start   (eval_q),
          .num     (m100),
          .den     (thr),
          .busy    (),
          .done    (done_v[p]),
          .quot    (quot_v[16*p +: 16])
        );
      end

      always @(posedge clk_sys)
      begin
        if (rst)
        begin
          mag_q      <= 48'h000000000000;
          state_q    <= `COND_NORMAL;
          rem_q      <= 20'h00000;
          exp_q      <= 19'h00000;
          rmax_q     <= 16'h0000;
          start_q    <= 1'b0;
          trip_q     <= 1'b0;
          blk_q      <= 1'b0;
          cond_q     <= `COND_NORMAL;
          ph_start_q <= 3'h0;
          ph_trip_q  <= 3'h0;
          fsel_q     <= `FORCE_NORMAL;
        end
        else if (ce)
        begin
          if (meas_valid)
          begin
            case (msel)
              `MAG_TRMS: mag_q <= trms_v;
              `MAG_P2P:  mag_q <= p2p_v;
              default:   mag_q <= fund_v;
            endcase
          end
          if (done_v[0])
            rmax_q <= (q01 > q2) ? q01 : q2;
          exp_q <= delay;
          case (state_q)
            `COND_NORMAL:
            begin
              if (eval2_q && any_pick)
              begin
                if (block_in[g])
                  state_q <= `COND_BLOCKED;
                else
                begin
                  state_q <= `COND_START;
                  rem_q   <= {1'b0, delay};
                end
              end
            end
            `COND_START:
            begin
              if (!any_pick)
              begin
                state_q <= `COND_NORMAL;
                rem_q   <= 20'h00000;
              end
              else if (block_in[g])
              begin
                state_q <= `COND_BLOCKED;
                rem_q   <= 20'h00000;
              end
              else if (rem_q == 20'h00000)
                state_q <= `COND_TRIP;
              else if (tick_q)
                rem_q <= rem_q - 20'h00001;
            end
            `COND_TRIP:
            begin
              if (!any_pick)
                state_q <= `COND_NORMAL;
            end
            `COND_BLOCKED:
            begin
              if (!any_pick)
                state_q <= `COND_NORMAL;
            end
            default: state_q <= `COND_NORMAL;
          endcase
          // real status merged with forced status
          start_q    <= (state_q == `COND_START) || fdec[6] || (|fdec[2:0]);
          trip_q     <= (state_q == `COND_TRIP) || fdec[7] || (|fdec[5:3]);
          blk_q      <= (state_q == `COND_BLOCKED) || fdec[8];
          ph_start_q <= ((state_q == `COND_START) ? pick_q : 3'h0) | fdec[2:0];
          ph_trip_q  <= ((state_q == `COND_TRIP) ? pick_q : 3'h0) | fdec[5:3];
          fsel_q     <= force_enable ? force_sel_q[5*g +: 5] : `FORCE_NORMAL;
          if (trip_q)
            cond_q <= `COND_TRIP;
          else if (start_q)
            cond_q <= `COND_START;
          else if (blk_q)
            cond_q <= `COND_BLOCKED;
          else
            cond_q <= `COND_NORMAL;
        end
      end

      assign start_out[g]                = start_q;
      assign trip_out[g]                 = trip_q;
      assign blocked_out[g]              = blk_q;
      assign condition[2*g +: 2]         = cond_q;
      assign phase_start[3*g +: 3]       = ph_start_q;
      assign phase_trip[3*g +: 3]        = ph_trip_q;
      assign forced_status_select[5*g +: 5] = fsel_q;
      assign expected_time[19*g +: 19]   = exp_q;
      assign time_remaining[20*g +: 20]  = rem_q;
      assign ratio_max[16*g +: 16]       = rmax_q;
      assign phase_ratio[48*g +: 48]     = quot_v;
    end
  endgenerate

endmodule // phase_overcurrent_stage

// ==== include/overcurrent_consts.vh ====
`ifndef OVERCURRENT_CONSTS_VH
`define OVERCURRENT_CONSTS_VH

// overall stage condition codes, also the stage state codes
`define COND_NORMAL       2'h0
`define COND_START        2'h1
`define COND_TRIP         2'h2
`define COND_BLOCKED      2'h3

// measured magnitude selection
`define MAG_RMS           2'h0
`define MAG_TRMS          2'h1
`define MAG_P2P           2'h2
`define MAG_RESET         2'h0

// forced status codes; phase variants follow A,B,C,AB,BC,CA,ABC
`define FORCE_NORMAL      5'h00
`define FORCE_START       5'h01
`define FORCE_TRIP        5'h02
`define FORCE_BLOCKED     5'h03
`define FORCE_START_A     5'h04
`define FORCE_START_ABC   5'h0a
`define FORCE_TRIP_A      5'h0b
`define FORCE_TRIP_ABC    5'h11

// pick-up threshold in 0.01 x nominal current
`define THR_RESET         16'h0078
`define THR_MIN           16'h000a
`define THR_MAX           16'h1388

// operate delay in 5 ms steps
`define DELAY_RESET       19'h00028
`define DELAY_MAX         19'h57e40

// ratio arithmetic
`define RATIO_SCALE       7'h64
`define RESET_PCT         7'h61
`define RATIO_MAX         16'h61a8

// time base
`define TIME_RES_NS       5000000
`define CLK_PERIOD_NS     4
// 5 ms of 4 ns cycles, sized to the tick counter
`define TICK_CYCLES       21'h1312d0

`endif

// ==== rtl/ratio_divider.v ====
`timescale 1ns/100ps
`include "overcurrent_consts.vh"

module ratio_divider #(
  parameter NW = 23,
  parameter DW = 16,
  parameter QW = 16,
  parameter CW = 5,
  parameter [QW-1:0] QMAX = `RATIO_MAX
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          rst,
  input  wire          ce,
  // operands
  input  wire          start,
  input  wire [NW-1:0] num,
  input  wire [DW-1:0] den,
  // result
  output reg           busy,
  output reg           done,
  output reg  [QW-1:0] quot
);

  reg  [NW-1:0] n_q;
  reg  [DW:0]   r_q;
  reg  [DW-1:0] d_q;
  reg  [CW-1:0] cnt_q;

  wire [DW:0]   r_sh  = {r_q[DW-1:0], n_q[NW-1]};
  wire          ge    = (r_sh >= {1'b0, d_q});
  wire [DW:0]   r_sub = r_sh - {1'b0, d_q};
  wire [NW-1:0] q_fin = {n_q[NW-2:0], ge};

  // restoring division, one quotient bit per cycle, saturated at the top
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      n_q   <= {NW{1'b0}};
      r_q   <= {(DW+1){1'b0}};
      d_q   <= {DW{1'b0}};
      cnt_q <= {CW{1'b0}};
      busy  <= 1'b0;
      done  <= 1'b0;
      quot  <= {QW{1'b0}};
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (start)
      begin
        n_q   <= num;
        d_q   <= den;
        r_q   <= {(DW+1){1'b0}};
        cnt_q <= NW[CW-1:0];
        busy  <= 1'b1;
      end
      else if (busy)
      begin
        r_q   <= ge ? r_sub : r_sh;
        n_q   <= q_fin;
        cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
        if (cnt_q == {{(CW-1){1'b0}}, 1'b1})
        begin
          busy <= 1'b0;
          done <= 1'b1;
          quot <= (q_fin > {{(NW-QW){1'b0}}, QMAX}) ? QMAX : q_fin[QW-1:0];
        end
      end
    end
  end

endmodule // ratio_divider

// ==== tb/overcurrent_props.sv ====
`timescale 1ns/100ps
`include "overcurrent_consts.vh"

module overcurrent_props #(
  parameter STAGES  = 4,
  parameter STAGE_W = 2,
  parameter GROUP_W = 3
) (
  // clock and reset
  input wire                 clk_sys,
  input wire                 rst,
  input wire                 ce,
  // controls
  input wire                 force_enable,
  input wire [GROUP_W-1:0]   active_group,
  input wire [STAGES-1:0]    block_in,
  input wire                 set_wr,
  input wire [15:0]          set_threshold,
  input wire [18:0]          set_delay,
  // outputs
  input wire                 set_refused,
  input wire [STAGES-1:0]    start_out,
  input wire [STAGES-1:0]    trip_out,
  input wire [STAGES-1:0]    blocked_out,
  input wire [2*STAGES-1:0]  condition,
  input wire [5*STAGES-1:0]  forced_status_select,
  input wire [19*STAGES-1:0] expected_time
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_FORCE_GATED: assert property (!force_enable && ce |=> forced_status_select == '0)
    else $error("forced selector visible while forcing is off");
  AST_RANGE_REFUSED: assert property (set_wr && ce && (set_threshold < `THR_MIN ||
    set_threshold > `THR_MAX || set_delay > `DELAY_MAX) |=> set_refused)
    else $error("out of range setting was accepted");
  AST_NO_STRAY_REFUSE: assert property (ce && !set_wr |=> !set_refused)
    else $error("refusal without a write");
  AST_TRIP_COND: assert property ($rose(trip_out[0]) && ce |=> condition[1:0] == `COND_TRIP)
    else $error("trip not shown in condition");
  AST_BLOCK_COND: assert property ($rose(blocked_out[0]) && ce && !trip_out[0] &&
    !start_out[0] |=> condition[1:0] == `COND_BLOCKED)
    else $error("blocked not shown in condition");
  AST_IDLE_COND: assert property (ce && !start_out[0] && !trip_out[0] && !blocked_out[0]
    |=> condition[1:0] == `COND_NORMAL)
    else $error("condition not normal while idle");
  AST_BLOCK_NO_START: assert property ((block_in[0] && !force_enable) [*5] |-> !start_out[0])
    else $error("start while blocked");
  AST_TRIP_AFTER_START: assert property ($rose(trip_out[0]) && !force_enable &&
    !$past(force_enable) && !$past(force_enable, 2) |-> $past(start_out[0]))
    else $error("unforced trip without start");
  AST_EXP_TIME_STABLE: assert property ((!set_wr && $stable(active_group)) [*4]
    |=> $stable(expected_time))
    else $error("expected time moved without cause");

  COV_START: cover property ($rose(start_out[0]));
  COV_TRIP: cover property ($rose(trip_out[0]));
  COV_BLOCKED: cover property ($rose(blocked_out[0]));
  COV_REFUSED: cover property (set_refused);
endmodule // overcurrent_props

// ==== tb/meas_front.sv ====
`timescale 1ns/100ps

module meas_front (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // magnitudes wanted by the bench, {C, B, A}
  input  wire [47:0] want_fund,
  input  wire [47:0] want_trms,
  input  wire [47:0] want_p2p,
  // measurement set toward the stage
  output reg         meas_valid = 1'b0,
  output reg  [15:0] phase_one_fundamental = 16'h0000,
  output reg  [15:0] phase_two_fundamental = 16'h0000,
  output reg  [15:0] phase_three_fundamental = 16'h0000,
  output reg  [15:0] phase_one_true_rms = 16'h0000,
  output reg  [15:0] phase_two_true_rms = 16'h0000,
  output reg  [15:0] phase_three_true_rms = 16'h0000,
  output reg  [15:0] phase_one_peak_to_peak = 16'h0000,
  output reg  [15:0] phase_two_peak_to_peak = 16'h0000,
  output reg  [15:0] phase_three_peak_to_peak = 16'h0000
);
  reg  [5:0] gap_q = 6'h00;
  wire       fire = (gap_q == 6'h3f) && !rst;

  // one full set every 64 cycles, well above the divider latency;
  // outside the valid cycle the lines carry inverted garbage
  always @(negedge clk_sys)
  begin
    gap_q <= rst ? 6'h00 : gap_q + 6'h01;
    meas_valid <= fire;
    {phase_three_fundamental, phase_two_fundamental, phase_one_fundamental}
      <= fire ? want_fund : ~want_fund;
    {phase_three_true_rms, phase_two_true_rms, phase_one_true_rms}
      <= fire ? want_trms : ~want_trms;
    {phase_three_peak_to_peak, phase_two_peak_to_peak, phase_one_peak_to_peak}
      <= fire ? want_p2p : ~want_p2p;
  end
endmodule // meas_front

// ==== tb/test_phase_overcurrent_stage.sv ====
`timescale 1ns/100ps
`include "overcurrent_consts.vh"

`define CHK(got, exp) \
  begin \
    total_checks = total_checks + 1; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch = n_mismatch + 1; \
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp); \
    end \
  end

module test_phase_overcurrent_stage;
  reg          clk_sys = 1'b0;
  reg          rst = 1'b1;
  reg          ce = 1'b1;
  reg          force_enable = 1'b0, gen_wr = 1'b0, set_wr = 1'b0, set_from_bus = 1'b0;
  reg          gen_comm_allow = 1'b0;
  reg  [2:0]   active_group = 3'h0, set_group = 3'h0;
  reg  [3:0]   block_in = 4'h0;
  reg  [1:0]   gen_stage = 2'h0, set_stage = 2'h0, gen_mag_sel = 2'h0;
  reg  [4:0]   gen_force_sel = 5'h00;
  reg  [15:0]  set_threshold = 16'h0000;
  reg  [18:0]  set_delay = 19'h00000;
  reg  [47:0]  want_fund = 48'h0, want_trms = 48'h0, want_p2p = 48'h0;
  wire         meas_valid, set_refused;
  wire [15:0]  phase_one_fundamental, phase_two_fundamental, phase_three_fundamental;
  wire [15:0]  phase_one_true_rms, phase_two_true_rms, phase_three_true_rms;
  wire [15:0]  phase_one_peak_to_peak, phase_two_peak_to_peak, phase_three_peak_to_peak;
  wire [3:0]   start_out, trip_out, blocked_out;
  wire [7:0]   condition;
  wire [11:0]  phase_start, phase_trip;
  wire [19:0]  forced_status_select;
  wire [75:0]  expected_time;
  wire [79:0]  time_remaining;
  wire [63:0]  ratio_max;
  wire [191:0] phase_ratio;
  integer      n_mismatch = 0, total_checks = 0, seed = 17, i, k, n;
  reg  [15:0]  mg [0:2];
  reg  [15:0]  mx;
  reg  [2:0]   pk;
  integer      cor [0:3] = '{16'h0065, 16'h0061, 16'h0060, 16'h0064};

  always #2 clk_sys = ~clk_sys;

  meas_front u_front (.clk_sys, .rst, .want_fund, .want_trms, .want_p2p, .meas_valid,
    .phase_one_fundamental, .phase_two_fundamental, .phase_three_fundamental,
    .phase_one_true_rms, .phase_two_true_rms, .phase_three_true_rms,
    .phase_one_peak_to_peak, .phase_two_peak_to_peak, .phase_three_peak_to_peak);

  phase_overcurrent_stage #(.TICK_CYCLES(21'h00000a)) u_dut (.clk_sys, .rst, .ce, .meas_valid,
    .phase_one_fundamental, .phase_two_fundamental, .phase_three_fundamental,
    .phase_one_true_rms, .phase_two_true_rms, .phase_three_true_rms,
    .phase_one_peak_to_peak, .phase_two_peak_to_peak, .phase_three_peak_to_peak,
    .force_enable, .active_group, .block_in, .gen_wr, .gen_stage, .gen_comm_allow,
    .gen_force_sel, .gen_mag_sel, .set_wr, .set_from_bus, .set_stage, .set_group,
    .set_threshold, .set_delay, .set_refused, .start_out, .trip_out, .blocked_out, .condition,
    .phase_start, .phase_trip, .forced_status_select, .expected_time, .time_remaining,
    .ratio_max, .phase_ratio);

  function [15:0] ratio(input [15:0] m);
    reg [31:0] q;
  begin
    q = ({16'h0000, m} * 32'd100) / 32'd100;
    ratio = (q > 32'd25000) ? `RATIO_MAX : q[15:0];
  end
  endfunction

  function [2:0] pmask(input integer c);
    pmask = (c - 4) % 7 == 0 ? 3'h1 : (c - 4) % 7 == 1 ? 3'h2 : (c - 4) % 7 == 2 ? 3'h4 :
      (c - 4) % 7 == 3 ? 3'h3 : (c - 4) % 7 == 4 ? 3'h6 : (c - 4) % 7 == 5 ? 3'h5 : 3'h7;
  endfunction

  task report_and_stop;
  begin
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask

  task hang(input integer lim);
  begin
    if (n >= lim)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t wait ran out", $time);
      report_and_stop;
    end
  end
  endtask

  // let two fresh measurement sets pass, then the divider latency
  task settle;
  begin
    k = 0;
    for (n = 0; n < 300 && k < 2; n = n + 1)
    begin
      @(negedge clk_sys);
      k = k + (meas_valid ? 1 : 0);
    end
    hang(300);
    repeat (30) @(negedge clk_sys);
  end
  endtask

  task await(input trip);
  begin
    for (n = 0; n < 400 && (trip ? trip_out[0] : start_out[0]) !== 1'b1; n = n + 1)
      @(negedge clk_sys);
    hang(400);
  end
  endtask

  task gen(input [4:0] fsel, input [1:0] mag);
  begin
    gen_comm_allow = 1'b1;
    gen_force_sel = fsel;
    gen_mag_sel = mag;
    gen_wr = 1'b1;
    @(negedge clk_sys);
    gen_wr = 1'b0;
  end
  endtask

  task setw(input bus, input [2:0] grp, input [15:0] thr, input [18:0] dly, input refused);
  begin
    set_from_bus = bus;
    set_group = grp;
    set_threshold = thr;
    set_delay = dly;
    set_wr = 1'b1;
    @(negedge clk_sys);
    set_wr = 1'b0;
    `CHK(set_refused, refused)
    @(negedge clk_sys);
  end
  endtask

  initial
  begin
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK(expected_time[18:0], `DELAY_RESET)
    `CHK(forced_status_select, 20'h00000)
    `CHK(condition, 8'h00)
    want_fund = 48'h0078;
    settle;
    `CHK(start_out, 4'h0)
    want_fund = 48'h0079;
    settle;
    `CHK(start_out, 4'hf)
    want_fund = 48'h0;
    settle;
    setw(1'b1, 3'h0, 16'h0064, 19'h00003, 1'b1);
    gen(`FORCE_NORMAL, `MAG_RMS);
    setw(1'b1, 3'h0, 16'h0064, 19'h00003, 1'b0);
    setw(1'b0, 3'h0, 16'h0009, 19'h00003, 1'b1);
    setw(1'b0, 3'h0, 16'h1389, 19'h00003, 1'b1);
    setw(1'b0, 3'h0, 16'h0064, 19'h57e41, 1'b1);
    repeat (3) @(negedge clk_sys);
    `CHK(expected_time[18:0], 19'h00003)
    active_group = 3'h2;
    setw(1'b1, 3'h2, 16'h0064, 19'h003e8, 1'b0);
    repeat (3) @(negedge clk_sys);
    `CHK(expected_time[18:0], 19'h003e8)
    pk = 3'h0;
    for (i = 0; i < 12; i = i + 1)
    begin
      mx = 16'h0000;
      for (k = 0; k < 3; k = k + 1)
      begin
        mg[k] = (i > 3) ? $unsigned($random(seed)) % 200 : (k > 0) ? 16'h0000 : cor[i];
        mx = (mg[k] > mx) ? mg[k] : mx;
        if (mg[k] > 16'h0064)
          pk[k] = 1'b1;
        else if (mg[k] * 100 < 9700)
          pk[k] = 1'b0;
      end
      want_fund = {mg[2], mg[1], mg[0]};
      settle;
      `CHK(start_out[0], |pk)
      `CHK(phase_start[2:0], pk)
      `CHK(phase_ratio[47:0], ({ratio(mg[2]), ratio(mg[1]), ratio(mg[0])}))
      `CHK(ratio_max[15:0], ratio(mx))
      if (|pk)
        `CHK(time_remaining[19:0] > 20'h0 && time_remaining[19:0] <= 20'h003e8, 1'b1)
      if (i == 0)
        `CHK(start_out[1], 1'b0)
    end
    for (i = 0; i < 3; i = i + 1)
    begin
      gen(`FORCE_NORMAL, i[1:0]);
      want_fund = (i == 0) ? 48'h0096 : 48'h0032;
      want_trms = (i == 1) ? 48'h0096 : 48'h0032;
      want_p2p = (i == 2) ? 48'h0096 : 48'h0032;
      settle;
      `CHK(start_out[0], 1'b1)
    end
    gen(`FORCE_NORMAL, `MAG_RMS);
    {want_fund, want_trms, want_p2p} = 144'h0;
    settle;
    active_group = 3'h0;
    repeat (3) @(negedge clk_sys);
    `CHK(expected_time[18:0], 19'h00003)
    want_fund = 48'h0096;
    await(1'b0);
    await(1'b1);
    `CHK(n >= 18 && n <= 36, 1'b1)
    repeat (2) @(negedge clk_sys);
    `CHK(condition[1:0], `COND_TRIP)
    `CHK(phase_trip[2:0], 3'h1)
    want_fund = 48'h0;
    settle;
    `CHK(condition[1:0], `COND_NORMAL)
    block_in = 4'h1;
    want_fund = 48'h0096;
    settle;
    `CHK(({blocked_out[0], start_out[0], condition[1:0]}), ({2'h2, `COND_BLOCKED}))
    want_fund = 48'h0;
    block_in = 4'h0;
    settle;
    gen(`FORCE_TRIP, `MAG_RMS);
    repeat (4) @(negedge clk_sys);
    `CHK(({forced_status_select[4:0], trip_out[0]}), 6'h00)
    force_enable = 1'b1;
    for (i = 0; i < 18; i = i + 1)
    begin
      gen(i[4:0], `MAG_RMS);
      repeat (4) @(negedge clk_sys);
      `CHK(forced_status_select[4:0], i[4:0])
      `CHK(start_out[0], i == 1 || (i >= 4 && i <= 10))
      `CHK(trip_out[0], i == 2 || i >= 11)
      `CHK(blocked_out[0], i == 3)
      if (i >= 4)
        `CHK(({phase_trip[2:0], phase_start[2:0]}), ({3'h0, pmask(i)} << (i > 10 ? 3 : 0)))
    end
    gen(5'h05, `MAG_RMS);
    repeat (2) @(negedge clk_sys);
    want_fund = 48'h0096;
    await(1'b1);
    `CHK(({start_out[0], phase_trip[2:0], phase_start[2:0]}), 7'h4a)
    want_fund = 48'h0;
    settle;
    force_enable = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK(({forced_status_select[4:0], trip_out[0]}), 6'h00)
    ce = 1'b0;
    want_fund = 48'h0096;
    settle;
    `CHK(start_out, 4'h0)
    report_and_stop;
  end
endmodule // test_phase_overcurrent_stage

bind phase_overcurrent_stage overcurrent_props #(.STAGES(STAGES), .STAGE_W(STAGE_W),
  .GROUP_W(GROUP_W)) u_props (.clk_sys, .rst, .ce, .force_enable, .active_group, .block_in,
  .set_wr, .set_threshold, .set_delay, .set_refused, .start_out, .trip_out, .blocked_out,
  .condition, .forced_status_select, .expected_time);
